// ---- hdl/isa_regs.vh ----
// Constants for the extended instruction decoder: offsets, fields, resets, opcodes
`ifndef ISA_REGS_VH
`define ISA_REGS_VH

// APB register byte offsets
`define OFS_CTRL        8'h00
`define OFS_WORK        8'h04
`define OFS_BANK        8'h08
`define OFS_STATUS      8'h0c
`define OFS_PTR0        8'h10
`define OFS_PTR1        8'h14
`define OFS_PTR2        8'h18
`define OFS_LATCH       8'h1c
`define OFS_PC          8'h20
`define OFS_STKPTR      8'h24

// Field positions
`define CTRL_EXT_BIT    0
`define STAT_Z_BIT      0
`define STAT_N_BIT      1
`define LATCH_U_LSB     8

// Reset values
`define RST_CTRL        1'h0
`define RST_WORK        8'h00
`define RST_BANK        4'h0
`define RST_PTR         12'h000
`define RST_PC          21'h000000
`define RST_LATCH_H     8'h00
`define RST_LATCH_U     5'h00

// Opcode patterns
`define OP_XOR_HI       6'h06
`define OP_PTR_ADJ_HI   7'h74
`define OP_PUSH_HI      8'hea
`define OP_MOVS_HI      8'heb
`define OP_CALL_W       16'h0014
`define OP_SECOND_HI    4'hf
`define SEL_RETURN      2'h3
`define IDX_LIMIT       8'h5f
`define ACC_HIGH_BANK   4'hf

// Instruction phases and timing
`define PH_Q1           2'h0
`define PH_Q2           2'h1
`define PH_Q3           2'h2
`define PH_Q4           2'h3
`define PC_STEP         21'h000002
`define STACK_DEPTH     5'h1f

`endif

// ---- hdl/ret_stack_mem.v ----
// Return stack storage with registered read data
module ret_stack_mem (
   // Clock
   input  wire        core_clk,
   // Write port
   input  wire        wr_en,
   input  wire [4:0]  wr_addr,
   input  wire [20:0] wr_data,
   // Read port
   input  wire [4:0]  rd_addr,
   output reg  [20:0] rd_data_q
);

   reg [20:0] mem_q [0:31];

   // Write and registered read
   always @(posedge core_clk) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
      rd_data_q <= mem_q[rd_addr];
   end

endmodule // ret_stack_mem

// ---- hdl/extended_isa_decoder.v ----
// Decode and execute logic for the exclusive-OR and extended instruction group
`include "isa_regs.vh"

module extended_isa_decoder (
   // Clock and reset
   input  wire        core_clk,
   input  wire        arst_n,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata_q,
   output reg         pready_q,
   output reg         pslverr_q,
   // Instruction fetch
   input  wire        instr_valid,
   input  wire [15:0] instr_word,
   output reg         instr_ack_q,
   output reg  [20:0] pc_q,
   output reg         pc_load_q,
   // Data memory
   output reg  [11:0] dmem_addr_q,
   output reg         dmem_re_q,
   output reg         dmem_we_q,
   output reg  [7:0]  dmem_wdata_q,
   input  wire [7:0]  dmem_rdata
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   reg        rst_meta_q;
   reg        rst_n_q;

   // Two-stage release of the asynchronous reset
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers
   function [11:0] file_addr;
      input        acc;
      input [7:0]  f;
      input [3:0]  bank;
      input        ext;
      input [11:0] base;
      begin
         if (acc) begin
            file_addr = {bank, f};
         end else if (ext && (f <= `IDX_LIMIT)) begin
            file_addr = base + {4'h0, f};
         end else if (f <= `IDX_LIMIT) begin
            file_addr = {4'h0, f};
         end else begin
            file_addr = {`ACC_HIGH_BANK, f};
         end
      end
   endfunction

   function [11:0] idx_addr;
      input [11:0] base;
      input [6:0]  off;
      begin
         idx_addr = base + {5'h00, off};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Architectural state
   reg        ext_en_q;
   reg [7:0]  work_q;
   reg [3:0]  bank_q;
   reg        neg_q;
   reg        zero_q;
   reg [7:0]  latch_h_q;
   reg [4:0]  latch_u_q;
   reg [4:0]  sp_q;
   wire [11:0] ptr_q [0:2];
   wire [20:0] tos_data;

   // Sequencer state
   reg [1:0]  phase_q;
   reg        cyc2_q;
   reg [15:0] op_q;
   reg [15:0] op2_q;
   reg [7:0]  data_q;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction decode
   wire is_xor   = (op_q[15:10] == `OP_XOR_HI);
   wire is_adj   = ext_en_q && (op_q[15:9] == `OP_PTR_ADJ_HI);
   wire is_ret   = is_adj && (op_q[7:6] == `SEL_RETURN);
   wire is_push  = ext_en_q && (op_q[15:8] == `OP_PUSH_HI);
   wire is_call_via_working_register = ext_en_q && (op_q == `OP_CALL_W);
   wire is_movs  = ext_en_q && (op_q[15:8] == `OP_MOVS_HI);
   wire two_cyc  = is_ret || is_call_via_working_register || is_movs;
   wire [1:0]  adj_sel = is_ret ? 2'h2 : op_q[7:6];
   wire [11:0] adj_lit = {6'h00, op_q[5:0]};
   wire [11:0] xor_addr = file_addr(op_q[8], op_q[7:0], bank_q, ext_en_q, ptr_q[2]);
   wire [11:0] movs_dst = (op_q[7] == 1'b0) ? op2_q[11:0]
                        : idx_addr(ptr_q[2], op2_q[6:0]);
   wire [7:0]  xor_res  = work_q ^ dmem_rdata;
   wire        apb_wr   = psel && penable && pready_q && pwrite;
   wire        q4_first = (phase_q == `PH_Q4) && !cyc2_q;

   ////////////////////////////////////////////////////////////////////////////
   // Pointer update selection
   reg        ptr_we [0:2];
   reg [11:0] ptr_wdata [0:2];
   integer    i;

   // Core updates the pointers in Q4; an APB write wins the same cycle
   always @* begin
      for (i = 0; i < 3; i = i + 1) begin
         ptr_we[i]    = 1'b0;
         ptr_wdata[i] = ptr_q[i];
      end
      if (q4_first && is_adj) begin
         ptr_we[adj_sel]    = 1'b1;
         ptr_wdata[adj_sel] = op_q[8] ? (ptr_q[adj_sel] - adj_lit)
                                      : (ptr_q[adj_sel] + adj_lit);
      end else if (q4_first && is_push) begin
         ptr_we[2]    = 1'b1;
         ptr_wdata[2] = ptr_q[2] - 12'h001;
      end
      if (apb_wr && (paddr == `OFS_PTR0)) begin
         ptr_we[0]    = 1'b1;
         ptr_wdata[0] = pwdata[11:0];
      end
      if (apb_wr && (paddr == `OFS_PTR1)) begin
         ptr_we[1]    = 1'b1;
         ptr_wdata[1] = pwdata[11:0];
      end
      if (apb_wr && (paddr == `OFS_PTR2)) begin
         ptr_we[2]    = 1'b1;
         ptr_wdata[2] = pwdata[11:0];
      end
   end

   // Three indirect pointer registers
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_ptr
         reg [11:0] val_q;
         always @(posedge core_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
               val_q <= `RST_PTR;
            end else if (ptr_we[g]) begin
               val_q <= ptr_wdata[g];
            end
         end
         assign ptr_q[g] = val_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Return stack
   wire       push_en = q4_first && is_call_via_working_register && (sp_q != `STACK_DEPTH);
   wire       pop_en  = q4_first && is_ret && (sp_q != 5'h00);

   ret_stack_mem u_stack (
      .core_clk  (core_clk),
      .wr_en     (push_en),
      .wr_addr   (sp_q),
      .wr_data   (pc_q),
      .rd_addr   (sp_q - 5'h01),
      .rd_data_q (tos_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Four-phase instruction sequencer
   always @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         phase_q      <= `PH_Q1;
         cyc2_q       <= 1'b0;
         op_q         <= 16'h0000;
         op2_q        <= 16'h0000;
         data_q       <= 8'h00;
         pc_q         <= `RST_PC;
         pc_load_q    <= 1'b0;
         instr_ack_q  <= 1'b0;
         sp_q         <= 5'h00;
         dmem_addr_q  <= 12'h000;
         dmem_re_q    <= 1'b0;
         dmem_we_q    <= 1'b0;
         dmem_wdata_q <= 8'h00;
      end else begin
         instr_ack_q <= 1'b0;
         pc_load_q   <= 1'b0;
         dmem_re_q   <= 1'b0;
         dmem_we_q   <= 1'b0;
         case (phase_q)
            `PH_Q1: begin
               if (!cyc2_q) begin
                  // Take the next instruction word
                  if (instr_valid) begin
                     op_q        <= instr_word;
                     pc_q        <= pc_q + `PC_STEP;
                     instr_ack_q <= 1'b1;
                     phase_q     <= `PH_Q2;
                  end
               end else if (is_movs) begin
                  // Second word of a move carries the destination
                  if (instr_valid) begin
                     op2_q       <= instr_word;
                     pc_q        <= pc_q + `PC_STEP;
                     instr_ack_q <= 1'b1;
                     phase_q     <= `PH_Q2;
                  end
               end else begin
                  phase_q <= `PH_Q2;
               end
            end
            `PH_Q2: begin
               // Issue the operand read
               if (!cyc2_q && is_xor) begin
                  dmem_addr_q <= xor_addr;
                  dmem_re_q   <= 1'b1;
               end else if (!cyc2_q && is_movs) begin
                  dmem_addr_q <= idx_addr(ptr_q[2], op_q[6:0]);
                  dmem_re_q   <= 1'b1;
               end
               phase_q <= `PH_Q3;
            end
            `PH_Q3: begin
               phase_q <= `PH_Q4;
            end
            `PH_Q4: begin
               phase_q <= `PH_Q1;
               cyc2_q  <= !cyc2_q && two_cyc;
               if (!cyc2_q) begin
                  if (is_xor && op_q[9]) begin
                     dmem_addr_q  <= xor_addr;
                     dmem_wdata_q <= xor_res;
                     dmem_we_q    <= 1'b1;
                  end
                  if (is_movs) begin
                     data_q <= dmem_rdata;
                  end
                  if (is_push) begin
                     dmem_addr_q  <= ptr_q[2];
                     dmem_wdata_q <= op_q[7:0];
                     dmem_we_q    <= 1'b1;
                  end
                  if (is_ret) begin
                     pc_q      <= tos_data;
                     pc_load_q <= 1'b1;
                     if (pop_en) begin
                        sp_q <= sp_q - 5'h01;
                     end
                  end
                  if (is_call_via_working_register) begin
                     pc_q      <= {latch_u_q, latch_h_q, work_q};
                     pc_load_q <= 1'b1;
                     if (push_en) begin
                        sp_q <= sp_q + 5'h01;
                     end
                  end
               end else if (is_movs) begin
                  dmem_addr_q  <= movs_dst;
                  dmem_wdata_q <= data_q;
                  dmem_we_q    <= 1'b1;
               end
            end
            default: begin
               phase_q <= `PH_Q1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Working register, bank, flags and control
   always @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ext_en_q  <= `RST_CTRL;
         work_q    <= `RST_WORK;
         bank_q    <= `RST_BANK;
         neg_q     <= 1'b0;
         zero_q    <= 1'b0;
         latch_h_q <= `RST_LATCH_H;
         latch_u_q <= `RST_LATCH_U;
      end else begin
         if (q4_first && is_xor) begin
            if (!op_q[9]) begin
               work_q <= xor_res;
            end
            neg_q  <= xor_res[7];
            zero_q <= (xor_res == 8'h00);
         end
         if (apb_wr) begin
            case (paddr)
               `OFS_CTRL:   ext_en_q <= pwdata[`CTRL_EXT_BIT];
               `OFS_WORK:   work_q   <= pwdata[7:0];
               `OFS_BANK:   bank_q   <= pwdata[3:0];
               `OFS_STATUS: begin
                  neg_q  <= pwdata[`STAT_N_BIT];
                  zero_q <= pwdata[`STAT_Z_BIT];
               end
               `OFS_LATCH: begin
                  latch_h_q <= pwdata[7:0];
                  latch_u_q <= pwdata[`LATCH_U_LSB+4:`LATCH_U_LSB];
               end
               default: begin
                  latch_h_q <= latch_h_q;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read mux and response
   reg [31:0] rd_mux;
   reg        rd_err;

   // Register read selection
   always @* begin
      rd_mux = 32'h00000000;
      rd_err = 1'b0;
      case (paddr)
         `OFS_CTRL:   rd_mux = {31'h00000000, ext_en_q};
         `OFS_WORK:   rd_mux = {24'h000000, work_q};
         `OFS_BANK:   rd_mux = {28'h0000000, bank_q};
         `OFS_STATUS: rd_mux = {30'h00000000, neg_q, zero_q};
         `OFS_PTR0:   rd_mux = {20'h00000, ptr_q[0]};
         `OFS_PTR1:   rd_mux = {20'h00000, ptr_q[1]};
         `OFS_PTR2:   rd_mux = {20'h00000, ptr_q[2]};
         `OFS_LATCH:  rd_mux = {19'h00000, latch_u_q, latch_h_q};
         `OFS_PC:     rd_mux = {11'h000, pc_q};
         `OFS_STKPTR: rd_mux = {27'h0000000, sp_q};
         default:     rd_err = 1'b1;
      endcase
   end

   // One wait-free access phase: answer raised in the cycle after setup
   always @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= psel && !penable && !pready_q;
         pslverr_q <= psel && !penable && !pready_q && rd_err;
         if (psel && !penable) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
         end
      end
   end

endmodule // extended_isa_decoder

// ---- hdl/extended_isa_decoder_end.v ----
// No logic here: the decoder and its return stack live in their own files

// ---- dv/isa_decoder_chk.sv ----
// Port-level checks for the extended instruction decoder
`include "isa_regs.vh"
module isa_decoder_chk (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        arst_n,
   // Register bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready_q,
   // Fetch and data memory
   input wire logic [15:0] instr_word,
   input wire logic        instr_ack_q,
   input wire logic        pc_load_q,
   input wire logic [11:0] dmem_addr_q,
   input wire logic        dmem_re_q,
   input wire logic        dmem_we_q,
   input wire logic [7:0]  dmem_wdata_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   logic [15:0] prev_q, word_q;
   logic        ext_q;
   logic [3:0]  bank_q;
   logic        bus_wr, tk, xr, adj, ret, call;
   ////////////////////////////////////////////////////////////////////////////
   // Word taken, extension enable and bank, as seen from the ports
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_q <= 16'h0000;
         word_q <= 16'h0000;
         ext_q <= 1'b0;
         bank_q <= 4'h0;
      end else begin
         prev_q <= instr_word;
         if (instr_ack_q) word_q <= prev_q;
         if (bus_wr && paddr == `OFS_CTRL) ext_q <= pwdata[`CTRL_EXT_BIT];
         if (bus_wr && paddr == `OFS_BANK) bank_q <= pwdata[3:0];
      end
   end
   // Decode of the word acknowledged this cycle
   assign bus_wr = psel && penable && pready_q && pwrite;
   assign tk = instr_ack_q && ext_q;
   assign xr = instr_ack_q && prev_q[15:10] == `OP_XOR_HI;
   assign adj = prev_q[15:9] == `OP_PTR_ADJ_HI;
   assign ret = adj && prev_q[7:6] == `SEL_RETURN;
   assign call = prev_q == `OP_CALL_W;
   ////////////////////////////////////////////////////////////////////////////
   property p_xor_read; xr |=> dmem_re_q; endproperty
   a_xor_read: assert property (p_xor_read) else $error("no operand read");
   property p_xor_dest; xr |-> ##3 (dmem_we_q == word_q[9]); endproperty
   a_xor_dest: assert property (p_xor_dest) else $error("wrong destination");
   property p_xor_bank; xr && prev_q[8] |=> dmem_addr_q == {bank_q, word_q[7:0]}; endproperty
   a_xor_bank: assert property (p_xor_bank) else $error("wrong banked address");
   property p_ext_off; instr_ack_q && !ext_q && prev_q[15:12] == 4'he |-> (!dmem_we_q && !pc_load_q)[*4]; endproperty
   a_ext_off: assert property (p_ext_off) else $error("disabled opcode acted");
   property p_adj_one; tk && adj && !ret |-> (!dmem_re_q && !dmem_we_q && !pc_load_q)[*4]; endproperty
   a_adj_one: assert property (p_adj_one) else $error("pointer adjust touched memory");
   property p_two_cycle; tk && (ret || call) |=> !instr_ack_q[*7]; endproperty
   a_two_cycle: assert property (p_two_cycle) else $error("word taken too soon");
   property p_ret_load; tk && ret |-> ##[1:8] pc_load_q; endproperty
   a_ret_load: assert property (p_ret_load) else $error("no return load");
   property p_call_load; tk && call |-> ##[1:8] pc_load_q; endproperty
   a_call_load: assert property (p_call_load) else $error("no call load");
   property p_ret_idle; tk && ret |-> (!dmem_we_q && !dmem_re_q)[*8]; endproperty
   a_ret_idle: assert property (p_ret_idle) else $error("memory used in return");
   property p_push; tk && prev_q[15:8] == `OP_PUSH_HI |-> ##[1:3] (dmem_we_q && dmem_wdata_q == word_q[7:0]); endproperty
   a_push: assert property (p_push) else $error("literal not stored");
   // Main scenarios reached
   c_xor_wr: cover property (xr && prev_q[9]);
   c_call: cover property (tk && call);
   c_ret: cover property (tk && ret);
endmodule // isa_decoder_chk

bind extended_isa_decoder isa_decoder_chk u_chk (
   .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready_q(pready_q), .instr_word(instr_word),
   .instr_ack_q(instr_ack_q), .pc_load_q(pc_load_q), .dmem_addr_q(dmem_addr_q),
   .dmem_re_q(dmem_re_q), .dmem_we_q(dmem_we_q), .dmem_wdata_q(dmem_wdata_q)
);

// ---- dv/isa_far_side.sv ----
// Behavioural instruction fetch queue and data memory facing the decoder
module isa_far_side (
   // Clock
   input  wire logic        core_clk,
   // Fetch
   input  wire logic        instr_ack_q,
   output logic             instr_valid,
   output logic [15:0]      instr_word,
   // Data memory
   input  wire logic [11:0] dmem_addr_q,
   input  wire logic        dmem_re_q,
   input  wire logic        dmem_we_q,
   input  wire logic [7:0]  dmem_wdata_q,
   output logic [7:0]       dmem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] q[$];
   logic [7:0]  mem [0:4095];
   logic        hold_q = 1'b0;
   logic        stall_q = 1'b0;
   logic        slow = 1'b0;
   initial begin
      instr_valid = 1'b0;
      instr_word = 16'h0000;
      dmem_rdata = 8'h00;
   end
   // Offer queued words, every other cycle when slow; idle word flips
   always @(posedge core_clk) begin
      if (instr_ack_q && q.size() > 0) void'(q.pop_front());
      stall_q <= ~stall_q;
      instr_valid <= q.size() > 0 && !(slow && stall_q);
      instr_word <= (q.size() > 0 && !(slow && stall_q)) ? q[0] : ~instr_word;
   end
   // Registered read held one more cycle, then scrambled
   always @(posedge core_clk) begin
      if (dmem_we_q) mem[dmem_addr_q] <= dmem_wdata_q;
      if (dmem_re_q) begin
         dmem_rdata <= mem[dmem_addr_q];
         hold_q <= 1'b1;
      end else if (hold_q) begin
         hold_q <= 1'b0;
      end else begin
         dmem_rdata <= ~dmem_rdata;
      end
   end
endmodule // isa_far_side

// ---- dv/extended_isa_decoder_bench.sv ----
// Self-checking bench for the extended instruction decoder
`include "isa_regs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module extended_isa_decoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata_q, rd_q;
   logic        pready_q, pslverr_q, err_q, instr_valid, instr_ack_q, pc_load_q, a, d;
   logic [15:0] instr_word;
   logic [20:0] pc_q, pc0;
   logic [11:0] dmem_addr_q, p2, ad, sw;
   logic        dmem_re_q, dmem_we_q;
   logic [7:0]  dmem_wdata_q, dmem_rdata, w8, m8, f8, rs;
   logic [31:0] r = 32'hb8ea3392;
   int          checks = 0;
   int          mismatches = 0;
   ////////////////////////////////////////////////////////////////////////////
   always #10 core_clk = ~core_clk;
   extended_isa_decoder dut (
      .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
      .instr_valid(instr_valid), .instr_word(instr_word), .instr_ack_q(instr_ack_q), .pc_q(pc_q),
      .pc_load_q(pc_load_q), .dmem_addr_q(dmem_addr_q), .dmem_re_q(dmem_re_q), .dmem_we_q(dmem_we_q),
      .dmem_wdata_q(dmem_wdata_q), .dmem_rdata(dmem_rdata));
   isa_far_side far (
      .core_clk(core_clk), .instr_ack_q(instr_ack_q), .instr_valid(instr_valid), .instr_word(instr_word),
      .dmem_addr_q(dmem_addr_q), .dmem_re_q(dmem_re_q), .dmem_we_q(dmem_we_q),
      .dmem_wdata_q(dmem_wdata_q), .dmem_rdata(dmem_rdata));
   ////////////////////////////////////////////////////////////////////////////
   // Random source and file address expectation
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [11:0] xaddr(input logic acc, input logic [7:0] f, input logic [3:0] b,
                                         input logic [11:0] p);
      if (acc) return {b, f};
      if (f <= 8'h5f) return p + {4'h0, f};
      return {4'hf, f};
   endfunction
   // One bus transfer; read data and error land in rd_q and err_q
   task automatic apb(input logic w, input logic [7:0] ad8, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad8;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready_q !== 1'b1 && n < 20);
      if (pready_q !== 1'b1) mismatches++;
      rd_q = prdata_q;
      err_q = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Queue one or two words and let the instruction finish
   task automatic exec(input logic [15:0] w0, input logic [15:0] w1, input logic two);
      int n;
      n = 0;
      far.q.push_back(w0);
      if (two) far.q.push_back(w1);
      while (far.q.size() > 0 && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 200) mismatches++;
      repeat (10) @(posedge core_clk);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         `CHK(rd_q, 32'h0)
      end
      apb(1'b0, 8'h28, 32'h0);
      `CHK(err_q, 1'b1)
      $display("test registers done");
      apb(1'b1, `OFS_PTR0, 32'h123);
      pc0 = pc_q;
      exec({`OP_PTR_ADJ_HI, 1'b0, 2'b00, 6'h05}, 16'h0, 1'b0);
      apb(1'b0, `OFS_PTR0, 32'h0);
      `CHK(rd_q, 32'h123)
      `CHK(pc_q, pc0 + 21'h2)
      $display("test extension off done");
      apb(1'b1, `OFS_CTRL, 32'h1);
      apb(1'b1, `OFS_STATUS, 32'h3);
      for (int i = 0; i < 6; i++) begin
         r = nxt(r);
         p2 = (i == 3) ? 12'h000 : r[11:0];
         f8 = (i == 5) ? 8'h3f : {2'b00, r[17:12]};
         apb(1'b1, 8'(`OFS_PTR0 + 4 * (i % 3)), {20'h0, p2});
         exec({`OP_PTR_ADJ_HI, i[0], 2'(i % 3), f8[5:0]}, 16'h0, 1'b0);
         apb(1'b0, 8'(`OFS_PTR0 + 4 * (i % 3)), 32'h0);
         `CHK(rd_q[11:0], i[0] ? p2 - f8[5:0] : p2 + f8[5:0])
      end
      apb(1'b0, `OFS_STATUS, 32'h0);
      `CHK(rd_q, 32'h3)
      $display("test pointer adjust done");
      for (int i = 0; i < 8; i++) begin
         r = nxt(r);
         far.slow = i[0];
         w8 = r[7:0];
         m8 = (i == 2) ? r[7:0] : r[15:8];
         f8 = (i == 0) ? 8'h5f : (i == 1) ? 8'h60 : r[23:16];
         a = (i < 2) ? 1'b0 : r[24];
         d = (i < 2) ? 1'b1 : r[25];
         p2 = {r[31:30], r[9:0]};
         ad = xaddr(a, f8, r[29:26], p2);
         far.mem[ad] = m8;
         apb(1'b1, `OFS_WORK, {24'h0, w8});
         apb(1'b1, `OFS_BANK, {28'h0, r[29:26]});
         apb(1'b1, `OFS_PTR2, {20'h0, p2});
         exec({`OP_XOR_HI, d, a, f8}, 16'h0, 1'b0);
         rs = w8 ^ m8;
         if (d) `CHK(far.mem[ad], rs)
         if (i < 2) `CHK(far.mem[ad], rs)
         apb(1'b0, `OFS_WORK, 32'h0);
         `CHK(rd_q[7:0], d ? w8 : rs)
         apb(1'b0, `OFS_STATUS, 32'h0);
         `CHK(rd_q[1:0], {rs[7], rs == 8'h00})
      end
      far.slow = 1'b0;
      $display("test exclusive-or done");
      for (int i = 0; i < 2; i++) begin
         r = nxt(r);
         apb(1'b1, `OFS_WORK, {24'h0, r[7:0]});
         apb(1'b1, `OFS_LATCH, {19'h0, r[20:8]});
         apb(1'b1, `OFS_PTR2, {20'h0, r[31:20]});
         pc0 = pc_q;
         exec(`OP_CALL_W, 16'h0, 1'b0);
         `CHK(pc_q, r[20:0])
         exec({`OP_PTR_ADJ_HI, i[0], `SEL_RETURN, r[26:21]}, 16'h0, 1'b0);
         `CHK(pc_q, pc0 + 21'h2)
         apb(1'b0, `OFS_PTR2, 32'h0);
         `CHK(rd_q[11:0], i[0] ? r[31:20] - r[26:21] : r[31:20] + r[26:21])
      end
      apb(1'b0, `OFS_STKPTR, 32'h0);
      `CHK(rd_q, 32'h0)
      $display("test call and return done");
      r = nxt(r);
      apb(1'b1, `OFS_PTR2, {20'h0, r[11:0]});
      exec({`OP_PUSH_HI, r[19:12]}, 16'h0, 1'b0);
      `CHK(far.mem[r[11:0]], r[19:12])
      apb(1'b0, `OFS_PTR2, 32'h0);
      `CHK(rd_q[11:0], r[11:0] - 12'h1)
      $display("test push done");
      for (int i = 0; i < 2; i++) begin
         r = nxt(r);
         p2 = r[11:0];
         ad = p2 + {5'h0, r[18:12]};
         far.mem[ad] = r[26:19];
         sw = i[0] ? {r[31:27], r[18:12] ^ 7'h40} : ad ^ 12'h800;
         apb(1'b1, `OFS_PTR2, {20'h0, p2});
         exec({`OP_MOVS_HI, i[0], r[18:12]}, {`OP_SECOND_HI, sw}, 1'b1);
         ad = i[0] ? p2 + {5'h0, sw[6:0]} : sw;
         `CHK(far.mem[ad], r[26:19])
      end
      $display("test moves done");
      test_done();
   end
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      test_done();
   end
endmodule // extended_isa_decoder_bench
